// [hdl/flash_ctrl_pkg.sv]
/*
  Constants for the flash program/erase controller: register offsets,
  field positions, reset values, block map, modes and bit-rate figures.
  Assumes a 16-bit register address and a 128-kbyte flash array.
*/
package flash_ctrl_pkg;
  // register offsets (low 16 address bits)
  localparam logic [15:0] RAM_OVERLAY_SELECT_ADDR     = 16'hFEDB;
  localparam logic [15:0] SYSTEM_CONTROL_TWO_ADDR     = 16'hFF42;
  localparam logic [15:0] FLASH_MODE_CONTROL_ADDR     = 16'hFFC8;
  localparam logic [15:0] FLASH_SETUP_STATUS_ADDR     = 16'hFFC9;
  localparam logic [15:0] ERASE_BLOCK_SELECT_ONE_ADDR = 16'hFFCA;
  localparam logic [15:0] ERASE_BLOCK_SELECT_TWO_ADDR = 16'hFFCB;
  // field positions
  localparam int WRITE_ENABLE_PIN_BIT = 7;
  localparam int SOFTWARE_WE_BIT      = 6;
  localparam int ERASE_VERIFY_BIT     = 3;
  localparam int PROGRAM_VERIFY_BIT   = 2;
  localparam int ERASE_BIT            = 1;
  localparam int PROGRAM_BIT          = 0;
  localparam int ERROR_FLAG_BIT       = 7;
  localparam int ERASE_SETUP_BIT      = 1;
  localparam int PROGRAM_SETUP_BIT    = 0;
  localparam int REGISTER_SELECT_BIT  = 3;
  localparam int OVERLAY_ENABLE_BIT   = 3;
  // reset values
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] ERASED_BYTE     = 8'hFF;
  // array geometry
  localparam int PAGE_BYTES  = 32;
  localparam int BLOCK_COUNT = 10;
  localparam int ADDR_WIDTH  = 17;
  localparam logic [16:0] BLOCK_BASE [BLOCK_COUNT] = '{
    17'h00000, 17'h00400, 17'h00800, 17'h00C00, 17'h01000,
    17'h08000, 17'h0C000, 17'h0E000, 17'h10000, 17'h18000};
  // mode pin codes
  localparam logic [1:0] MD_HIGH_WRITER   = 2'h0;
  localparam logic [1:0] MD_HIGH_BOOT     = 2'h1;
  localparam logic [1:0] MD_HIGH_DISABLED = 2'h2;
  // boot-mode bit rates
  localparam int CLK_HZ    = 200000000;
  localparam int BAUD_FAST = 9600;
  localparam int BAUD_SLOW = 4800;
  localparam int PIN_SETTLE_CYCLES = 2;

  typedef enum logic [2:0] {
    op_disabled     = 3'b000,
    op_user         = 3'b001,
    op_user_program = 3'b010,
    op_boot         = 3'b011,
    op_writer       = 3'b100
  } op_mode_type;

  typedef enum logic [1:0] {
    baud_idle    = 2'b00,
    baud_measure = 2'b01,
    baud_locked  = 2'b10
  } baud_state_type;
endpackage

// [hdl/flash_program_erase_control.sv]
/*
  Flash program/erase controller: control registers, protection,
  reset-start mode selection, page latch, block erase, RAM overlay
  decode and boot-mode bit-rate detection.
  Assumes a single-cycle register port from the CPU, pins arriving
  asynchronously, and an array macro that acts on level commands.
*/
`timescale 1ns/1ps

// Overview of operation
// - programming presents one whole 32-byte page to the array at once
// - erase acts on exactly one selected block; several blocks go serially
// - array is ten erase blocks of 1k x4, 28k, 16k, 8k x2, 32k x2
// - operating mode is taken from mode pins and write-enable pin at reset
// - plain user mode reads flash but refuses program and erase
// - program and erase only in boot, user program and writer modes
// - boot mode erases the whole array to FF, ignoring blocks
// - boot mode detects host bit rate of 9600 or 4800 bps
// - overlay enabled: accesses to selected block go to overlay RAM
// - clearing overlay enable releases the overlay back to flash
// - flash registers decode only while register-select bit is 1
// - flash-disabled modes read flash registers as 00, ignore writes
// - flash register writes ignored while write-enable status bit is 0
// - first control register resets to 80 with pin high, else 00
// - setup and block registers held zero without pin and software enable
// - flash registers are 8-bit, byte access, two states per access
// - low write-enable pin is hardware protection against program/erase
// - hardware, software and error protection each block program/erase/verify
// - program needs software enable, then setup, then program bit
// - fault during program or erase sets error flag, entering error protect
module flash_program_erase_control #(
  parameter int PAGE_BYTES      = flash_ctrl_pkg::PAGE_BYTES,
  parameter int FAST_BIT_CYCLES =
    flash_ctrl_pkg::CLK_HZ / flash_ctrl_pkg::BAUD_FAST,
  parameter int SLOW_BIT_CYCLES =
    flash_ctrl_pkg::CLK_HZ / flash_ctrl_pkg::BAUD_SLOW
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic [15:0]             reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  input  wire logic                    reg_write_i,
  input  wire logic                    reg_read_i,
  output logic      [7:0]              reg_rdata_o,
  input  wire logic                    flash_write_enable_pin_i,
  input  wire logic                    mode_select_pin_2_i,
  input  wire logic                    mode_select_pin_1_i,
  input  wire logic                    mode_select_pin_0_i,
  input  wire logic                    writer_mode_pin_2_i,
  input  wire logic                    writer_mode_pin_1_i,
  input  wire logic                    writer_mode_pin_0_i,
  input  wire logic                    serial_receive_i,
  output logic                         serial_transmit_o,
  input  wire logic                    flash_wr_i,
  input  wire logic [16:0]             flash_addr_i,
  input  wire logic [7:0]              flash_wdata_i,
  output logic                         overlay_hit_o,
  output logic      [9:0]              overlay_ram_addr_o,
  output logic                         array_program_o,
  output logic                         array_erase_o,
  output logic                         array_erase_all_o,
  output logic                         array_verify_o,
  output logic      [16:0]             array_page_addr_o,
  output logic      [PAGE_BYTES*8-1:0] array_page_data_o,
  output logic      [9:0]              array_block_o,
  output logic      [16:0]             array_erase_base_o,
  input  wire logic                    array_fault_i,
  output logic      [2:0]              op_mode_o,
  output logic      [2:0]              writer_select_o,
  output logic                         baud_locked_o,
  output logic      [15:0]             bit_cycles_o
);
  localparam int PW = $clog2(PAGE_BYTES);
  localparam int NB = flash_ctrl_pkg::BLOCK_COUNT;

  // refuse shapes that the page latch and rate counter cannot serve
  if (PAGE_BYTES < 2 || PAGE_BYTES > 64 || (1 << PW) != PAGE_BYTES ||
      SLOW_BIT_CYCLES > 65535 || FAST_BIT_CYCLES < 4 ||
      SLOW_BIT_CYCLES <= FAST_BIT_CYCLES) begin : g_bad_param
    $error("flash controller parameters out of range");
  end

  logic       rst_meta;
  logic       rst_n;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [1:0] settle_cnt;
  logic       captured;
  flash_ctrl_pkg::op_mode_type op_mode;
  logic [7:0] sys_ctrl_two;
  logic [7:0] overlay_sel;
  logic       software_write_enable;
  logic       ev;
  logic       pv;
  logic       erase_bit;
  logic       prog_bit;
  logic       flash_error_flag;
  logic       erase_setup;
  logic       program_setup;
  logic [7:0] ebr_one;
  logic [1:0] ebr_two;
  logic [7:0] page_mem [PAGE_BYTES];
  flash_ctrl_pkg::baud_state_type baud_state;
  logic [15:0] low_cnt;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // pins: write enable, mode, writer mode, receive; meta feeds sync only
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= {flash_write_enable_pin_i, mode_select_pin_2_i,
                   mode_select_pin_1_i, mode_select_pin_0_i,
                   writer_mode_pin_2_i, writer_mode_pin_1_i,
                   writer_mode_pin_0_i, serial_receive_i};
      pin_sync <= pin_meta;
    end
  end

  wire       flash_write_enable_pin = pin_sync[7];
  wire [2:0] md                     = pin_sync[6:4];
  wire [2:0] pf                     = pin_sync[3:1];
  wire       rx                     = pin_sync[0];
  wire       tr_done                =
    settle_cnt == 2'(flash_ctrl_pkg::PIN_SETTLE_CYCLES);

  // mode pins decode; chosen once after the sync chain has filled
  flash_ctrl_pkg::op_mode_type pin_mode;
  assign pin_mode =
    (md[2:1] == flash_ctrl_pkg::MD_HIGH_DISABLED) ?
      flash_ctrl_pkg::op_disabled :
    (md[2:1] == flash_ctrl_pkg::MD_HIGH_WRITER) ?
      flash_ctrl_pkg::op_writer :
    (md[2:1] == flash_ctrl_pkg::MD_HIGH_BOOT) ?
      (flash_write_enable_pin ? flash_ctrl_pkg::op_boot :
                                flash_ctrl_pkg::op_user) :
      (flash_write_enable_pin ? flash_ctrl_pkg::op_user_program :
                                flash_ctrl_pkg::op_user);

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 2'h0;
      captured   <= 1'b0;
      op_mode    <= flash_ctrl_pkg::op_disabled;
    end else if (!captured) begin
      settle_cnt <= settle_cnt + 2'h1;
      if (tr_done) begin
        captured <= 1'b1;
        op_mode  <= pin_mode;
      end
    end
  end

  // protection and decode terms
  wire mode_ok  = op_mode == flash_ctrl_pkg::op_boot ||
                  op_mode == flash_ctrl_pkg::op_user_program ||
                  op_mode == flash_ctrl_pkg::op_writer;
  wire hw_prot  = !flash_write_enable_pin;
  wire allowed  = mode_ok && !hw_prot && software_write_enable &&
                  !flash_error_flag;
  wire is_boot  = op_mode == flash_ctrl_pkg::op_boot;
  wire fl_on    = sys_ctrl_two[flash_ctrl_pkg::REGISTER_SELECT_BIT] &&
                  op_mode != flash_ctrl_pkg::op_disabled;
  wire hit_mc1  = fl_on &&
                  reg_addr_i == flash_ctrl_pkg::FLASH_MODE_CONTROL_ADDR;
  wire hit_mc2  = fl_on &&
                  reg_addr_i == flash_ctrl_pkg::FLASH_SETUP_STATUS_ADDR;
  wire hit_eb1  = fl_on &&
                  reg_addr_i == flash_ctrl_pkg::ERASE_BLOCK_SELECT_ONE_ADDR;
  wire hit_eb2  = fl_on &&
                  reg_addr_i == flash_ctrl_pkg::ERASE_BLOCK_SELECT_TWO_ADDR;
  wire hit_sc2  = reg_addr_i == flash_ctrl_pkg::SYSTEM_CONTROL_TWO_ADDR;
  wire hit_ovl  = reg_addr_i == flash_ctrl_pkg::RAM_OVERLAY_SELECT_ADDR;
  wire fl_wr    = reg_write_i && flash_write_enable_pin;
  wire sw_on    = flash_write_enable_pin && software_write_enable;
  wire keep_on  = sw_on;
  wire [9:0] blocks  = {ebr_two, ebr_one};
  wire one_block     = blocks != 10'h000 &&
                       (blocks & (blocks - 10'h001)) == 10'h000;

  // bus-visible register images
  wire [7:0] mc1_val = {flash_write_enable_pin, software_write_enable,
                        2'b00, ev, pv, erase_bit, prog_bit};
  wire [7:0] mc2_val = {flash_error_flag, 5'b00000, erase_setup,
                        program_setup};
  wire [7:0] read_value =
    hit_mc1 ? mc1_val :
    hit_mc2 ? mc2_val :
    hit_eb1 ? ebr_one :
    hit_eb2 ? {6'b000000, ebr_two} :
    hit_sc2 ? sys_ctrl_two :
    hit_ovl ? overlay_sel : flash_ctrl_pkg::REG_RESET_VALUE;

  // byte-wide read data in the cycle after the strobe only
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) reg_rdata_o <= 8'h00;
    else        reg_rdata_o <= reg_read_i ? read_value : 8'h00;
  end

  // plain registers that do not alias the flash block
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sys_ctrl_two <= flash_ctrl_pkg::REG_RESET_VALUE;
      overlay_sel  <= flash_ctrl_pkg::REG_RESET_VALUE;
    end else begin
      if (reg_write_i && hit_sc2) sys_ctrl_two <= reg_wdata_i;
      if (reg_write_i && hit_ovl) overlay_sel  <= reg_wdata_i;
    end
  end

  // control bits; each setting condition gates its own write
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      software_write_enable <= 1'b0;
      ev  <= 1'b0;
      pv  <= 1'b0;
      erase_bit <= 1'b0;
      prog_bit  <= 1'b0;
      erase_setup   <= 1'b0;
      program_setup <= 1'b0;
      ebr_one <= flash_ctrl_pkg::REG_RESET_VALUE;
      ebr_two <= 2'b00;
    end else if (!keep_on) begin
      // without pin and software enable only software enable may be set
      software_write_enable <= fl_wr && hit_mc1 &&
        reg_wdata_i[flash_ctrl_pkg::SOFTWARE_WE_BIT];
      ev  <= 1'b0;
      pv  <= 1'b0;
      erase_bit <= 1'b0;
      prog_bit  <= 1'b0;
      erase_setup   <= 1'b0;
      program_setup <= 1'b0;
      ebr_one <= 8'h00;
      ebr_two <= 2'b00;
    end else begin
      if (fl_wr && hit_mc1) begin
        software_write_enable <=
          reg_wdata_i[flash_ctrl_pkg::SOFTWARE_WE_BIT];
        ev  <= reg_wdata_i[flash_ctrl_pkg::ERASE_VERIFY_BIT];
        pv  <= reg_wdata_i[flash_ctrl_pkg::PROGRAM_VERIFY_BIT];
        erase_bit <= erase_setup &&
                     reg_wdata_i[flash_ctrl_pkg::ERASE_BIT];
        prog_bit  <= program_setup &&
                     reg_wdata_i[flash_ctrl_pkg::PROGRAM_BIT];
      end
      if (fl_wr && hit_mc2) begin
        erase_setup   <= reg_wdata_i[flash_ctrl_pkg::ERASE_SETUP_BIT];
        program_setup <=
          reg_wdata_i[flash_ctrl_pkg::PROGRAM_SETUP_BIT];
      end
      if (fl_wr && hit_eb1) ebr_one <= reg_wdata_i;
      if (fl_wr && hit_eb2) ebr_two <= reg_wdata_i[1:0];
    end
  end

  // error flag: sticky until reset, so no clear can race a fault
  wire op_busy   = array_program_o || array_erase_o || array_erase_all_o;
  wire bad_erase = erase_bit && allowed && !is_boot && !one_block;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flash_error_flag <= 1'b0;
    end else if ((array_fault_i && op_busy) || bad_erase) begin
      flash_error_flag <= 1'b1;
    end
  end

  // page latch collects CPU writes; frozen while a program runs
  wire page_wr = flash_wr_i && software_write_enable && !prog_bit;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        page_mem[i] <= flash_ctrl_pkg::ERASED_BYTE;
      end
      array_page_addr_o <= 17'h00000;
    end else if (page_wr) begin
      page_mem[flash_addr_i[PW-1:0]] <= flash_wdata_i;
      array_page_addr_o <= {flash_addr_i[16:PW], PW'(0)};
    end
  end

  // page image and erase base per entry
  logic [16:0] base_acc [NB+1];
  assign base_acc[0] = 17'h00000;
  for (genvar g = 0; g < NB; g++) begin : g_block
    assign base_acc[g+1] = base_acc[g] |
      (blocks[g] ? flash_ctrl_pkg::BLOCK_BASE[g] : 17'h00000);
  end
  for (genvar g = 0; g < PAGE_BYTES; g++) begin : g_page
    assign array_page_data_o[g*8 +: 8] = page_mem[g];
  end

  // array commands: levels, each a flop, all forced off when protected
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      array_program_o    <= 1'b0;
      array_erase_o      <= 1'b0;
      array_erase_all_o  <= 1'b0;
      array_verify_o     <= 1'b0;
      array_block_o      <= 10'h000;
      array_erase_base_o <= 17'h00000;
    end else begin
      array_program_o   <= prog_bit && allowed;
      array_erase_o     <= erase_bit && allowed && !is_boot &&
                           one_block;
      array_erase_all_o <= erase_bit && allowed && is_boot;
      array_verify_o    <= (ev || pv) && allowed;
      array_block_o     <= blocks;
      array_erase_base_o <= base_acc[NB];
    end
  end

  // overlay redirects accesses to the chosen 1-kbyte block
  assign overlay_hit_o =
    overlay_sel[flash_ctrl_pkg::OVERLAY_ENABLE_BIT] &&
    flash_addr_i[16:10] == {5'b00000, overlay_sel[1:0]};
  assign overlay_ram_addr_o = flash_addr_i[9:0];

  // boot bit rate: width of the first low start bit picks the rate
  localparam int SPLIT_CYCLES = (FAST_BIT_CYCLES + SLOW_BIT_CYCLES) / 2;
  localparam int GLITCH_CYCLES = FAST_BIT_CYCLES / 2;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      baud_state   <= flash_ctrl_pkg::baud_idle;
      low_cnt      <= 16'h0000;
      bit_cycles_o <= 16'h0000;
    end else begin
      unique case (baud_state)
        flash_ctrl_pkg::baud_idle: begin
          low_cnt <= 16'h0000;
          if (is_boot && !rx) baud_state <= flash_ctrl_pkg::baud_measure;
        end
        flash_ctrl_pkg::baud_measure: begin
          if (!rx) begin
            if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
          end else if (low_cnt < 16'(GLITCH_CYCLES)) begin
            baud_state <= flash_ctrl_pkg::baud_idle;  // too short: noise
          end else begin
            baud_state   <= flash_ctrl_pkg::baud_locked;
            bit_cycles_o <= (low_cnt > 16'(SPLIT_CYCLES)) ?
              16'(SLOW_BIT_CYCLES) : 16'(FAST_BIT_CYCLES);
          end
        end
        flash_ctrl_pkg::baud_locked: begin
          low_cnt <= 16'h0000;
        end
      endcase
    end
  end

  // serial transfer itself lives elsewhere; line idles high here
  assign serial_transmit_o = 1'b1;
  assign baud_locked_o     = baud_state == flash_ctrl_pkg::baud_locked;
  assign op_mode_o         = op_mode;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) writer_select_o <= 3'b000;
    else writer_select_o <= (op_mode == flash_ctrl_pkg::op_writer) ?
                            pf : 3'b000;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  property p_prog_gated;
    array_program_o |-> $past(prog_bit) && $past(allowed);
  endproperty
  a_prog_gated: assert property (p_prog_gated)
    else $error("program ran while protected");

  property p_hw_protect;
    !flash_write_enable_pin [*2] |->
      !array_program_o && !array_erase_o && !array_erase_all_o;
  endproperty
  a_hw_protect: assert property (p_hw_protect)
    else $error("array command with write-enable pin low");

  property p_disabled_reads;
    reg_read_i && op_mode == flash_ctrl_pkg::op_disabled &&
    reg_addr_i == flash_ctrl_pkg::FLASH_MODE_CONTROL_ADDR
    |=> reg_rdata_o == 8'h00;
  endproperty
  a_disabled_reads: assert property (p_disabled_reads)
    else $error("disabled mode read not zero");

  property p_select_off;
    reg_read_i && !sys_ctrl_two[flash_ctrl_pkg::REGISTER_SELECT_BIT] &&
    reg_addr_i == flash_ctrl_pkg::ERASE_BLOCK_SELECT_ONE_ADDR
    |=> reg_rdata_o == 8'h00;
  endproperty
  a_select_off: assert property (p_select_off)
    else $error("flash register decoded with select clear");

  property p_fwe_write;
    reg_write_i && !flash_write_enable_pin |=> !software_write_enable;
  endproperty
  a_fwe_write: assert property (p_fwe_write)
    else $error("write accepted with write-enable bit clear");

  property p_one_block;
    array_erase_o |-> $onehot(array_block_o) && !array_erase_all_o;
  endproperty
  a_one_block: assert property (p_one_block)
    else $error("erase on other than one block");

  property p_user_mode;
    op_mode == flash_ctrl_pkg::op_user ##1 1'b1
    |-> !array_program_o && !array_erase_o && !array_verify_o;
  endproperty
  a_user_mode: assert property (p_user_mode)
    else $error("array command in user mode");

  property p_hold_zero;
    !software_write_enable |=> !erase_setup && !program_setup &&
                               ebr_one == 8'h00 && ebr_two == 2'b00;
  endproperty
  a_hold_zero: assert property (p_hold_zero)
    else $error("setup or block bits kept without enable");

  property p_fault_flag;
    array_fault_i && op_busy |=> flash_error_flag [*2];
  endproperty
  a_fault_flag: assert property (p_fault_flag)
    else $error("fault did not set sticky error flag");

  property p_rate;
    $rose(baud_locked_o) |-> bit_cycles_o == 16'(FAST_BIT_CYCLES) ||
                             bit_cycles_o == 16'(SLOW_BIT_CYCLES);
  endproperty
  a_rate: assert property (p_rate)
    else $error("bit rate not one of the two rates");
endmodule

// [tb/array_model.sv]
/*
  Behavioural flash array seen from the controller: raises a one-cycle
  fault while an operation runs, only when the bench asks for one.
  Assumes the controller's clock and the raw active-low reset.
*/
`timescale 1ns/1ps

module array_model (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic busy_i,
  input  wire logic fault_req_i,
  output logic      array_fault_o
);
  // fault only in the cycle after a live program or erase cycle, never two in a row
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      array_fault_o <= 1'b0;
    end else begin
      array_fault_o <= busy_i & fault_req_i & !array_fault_o;
    end
  end
endmodule

// [tb/flash_program_erase_control_bench.sv]
/*
  Register-level bench: reset-start modes, register gating, program,
  erase, fault, overlay decode, boot rate and writer pins.
  Assumes short bit-rate parameters and the array model beside it.
*/
`timescale 1ns/1ps

module flash_program_erase_control_bench;
  localparam int FAST = 40;
  localparam int SLOW = 80;
  logic        clk = 1'b0;
  logic        rn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wd = 8'h00;
  logic        wr = 1'b0;
  logic        rdq = 1'b0;
  logic [7:0]  rdat;
  logic        flash_write_enable_pin = 1'b1;
  logic [2:0]  md = 3'h6;
  logic [2:0]  wp = 3'h0;
  logic        rx = 1'b1;
  logic        fwr = 1'b0;
  logic [16:0] fa = 17'h00000;
  logic [7:0]  fd = 8'h00;
  logic        freq = 1'b0;
  logic        flt;
  logic        tx;
  logic        hit, pg, er, era, vf, lk;
  logic [9:0]  oa, blk;
  logic [16:0] pa, eb;
  logic [255:0] pd;
  logic [2:0]  om, ws;
  logic [15:0] bc;
  logic [7:0]  v;
  int          fails = 0;
  int          samples_checked = 0;

  always #2.5 clk = ~clk;

  flash_program_erase_control #(.FAST_BIT_CYCLES(FAST),
    .SLOW_BIT_CYCLES(SLOW)) i_dut (
    .sys_clk_i(clk), .reset_n_i(rn), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_write_i(wr), .reg_read_i(rdq),
    .reg_rdata_o(rdat), .flash_write_enable_pin_i(flash_write_enable_pin),
    .mode_select_pin_2_i(md[2]), .mode_select_pin_1_i(md[1]),
    .mode_select_pin_0_i(md[0]), .writer_mode_pin_2_i(wp[2]),
    .writer_mode_pin_1_i(wp[1]), .writer_mode_pin_0_i(wp[0]),
    .serial_receive_i(rx), .serial_transmit_o(tx), .flash_wr_i(fwr),
    .flash_addr_i(fa), .flash_wdata_i(fd), .overlay_hit_o(hit),
    .overlay_ram_addr_o(oa), .array_program_o(pg), .array_erase_o(er),
    .array_erase_all_o(era), .array_verify_o(vf),
    .array_page_addr_o(pa), .array_page_data_o(pd),
    .array_block_o(blk), .array_erase_base_o(eb), .array_fault_i(flt),
    .op_mode_o(om), .writer_select_o(ws), .baud_locked_o(lk),
    .bit_cycles_o(bc));

  array_model i_array (.sys_clk_i(clk), .reset_n_i(rn),
    .busy_i(pg | er), .fault_req_i(freq), .array_fault_o(flt));

  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task chk(input logic [16:0] got, input logic [16:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle strobes, released at the edge that takes them
  task wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rreg(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    rdq <= 1'b1; addr <= a;
    @(posedge clk);
    rdq <= 1'b0;
    #1 chk({9'h000, rdat}, {9'h000, e});
  endtask

  // pins held steady through reset so mode capture sees them
  task rst(input logic f, input logic [2:0] m);
    @(posedge clk);
    rn <= 1'b0; flash_write_enable_pin <= f; md <= m; freq <= 1'b0;
    repeat (6) @(posedge clk);
    rn <= 1'b1;
    repeat (12) @(posedge clk);
  endtask

  initial begin
    #400us;
    fails++;
    stop_test();
  end

  initial begin
    rst(1'b1, 3'h6);
    chk(om, 17'h2);
    chk(tx, 17'h1);
    rreg(16'hFFC8, 8'h00);
    rreg(16'hFFCA, 8'h00);
    rreg(16'h1234, 8'h00);
    wreg(16'hFF42, 8'h08);
    rreg(16'hFFC8, 8'h80);
    wreg(16'hFFC9, 8'h01);
    rreg(16'hFFC9, 8'h00);
    // overlay on block 2, then released
    wreg(16'hFEDB, 8'h0A);
    @(posedge clk) fa <= 17'h00805;
    #1 chk({6'h0, hit, oa}, {6'h0, 1'b1, 10'h005});
    @(posedge clk) fa <= 17'h00C05;
    #1 chk(hit, 17'h0);
    wreg(16'hFEDB, 8'h02);
    @(posedge clk) fa <= 17'h00805;
    #1 chk(hit, 17'h0);
    // page latch then program sequence
    wreg(16'hFFC8, 8'h40);
    @(posedge clk) begin fwr <= 1'b1; fa <= 17'h00023; fd <= 8'h5A; end
    @(posedge clk) fwr <= 1'b0;
    wreg(16'hFFC9, 8'h01);
    wreg(16'hFFC8, 8'h41);
    repeat (2) @(posedge clk);
    #1 chk(pg, 17'h1);
    chk(pa, 17'h00020);
    chk(pd[31:24], 17'h5A);
    wreg(16'hFFC8, 8'h44);
    repeat (2) @(posedge clk);
    #1 chk({vf, pg}, 17'h2);
    wreg(16'hFFC8, 8'h40);
    wreg(16'hFFC9, 8'h00);
    // single erase of the 28-kbyte block, then a fault
    wreg(16'hFFCA, 8'h10);
    wreg(16'hFFC9, 8'h02);
    wreg(16'hFFC8, 8'h42);
    repeat (2) @(posedge clk);
    #1 chk({er, pg}, 17'h2);
    chk(blk, 17'h010);
    chk(eb, 17'h01000);
    freq <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(er, 17'h0);
    @(posedge clk) rdq <= 1'b1;
    addr <= 16'hFFC9;
    @(posedge clk) rdq <= 1'b0;
    #1 chk(rdat[7], 17'h1);
    // user mode: pin low protects and reads 00
    rst(1'b0, 3'h6);
    chk(om, 17'h1);
    wreg(16'hFF42, 8'h08);
    rreg(16'hFFC8, 8'h00);
    wreg(16'hFFC8, 8'h40);
    wreg(16'hFFC8, 8'h41);
    rreg(16'hFFC8, 8'h00);
    chk(pg, 17'h0);
    // flash disabled
    rst(1'b1, 3'h4);
    wreg(16'hFF42, 8'h08);
    wreg(16'hFFC8, 8'h40);
    rreg(16'hFFC8, 8'h00);
    // boot mode: whole-array erase and rate detection
    rst(1'b1, 3'h2);
    chk(om, 17'h3);
    wreg(16'hFF42, 8'h08);
    wreg(16'hFFC8, 8'h40);
    wreg(16'hFFC9, 8'h02);
    wreg(16'hFFC8, 8'h42);
    repeat (2) @(posedge clk);
    #1 chk(era, 17'h1);
    @(posedge clk) rx <= 1'b0;
    repeat (FAST) @(posedge clk);
    rx <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk({lk, bc}, {1'b1, 16'(FAST)});
    rst(1'b1, 3'h2);
    @(posedge clk) rx <= 1'b0;
    repeat (SLOW) @(posedge clk);
    rx <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk({lk, bc}, {1'b1, 16'(SLOW)});
    // writer mode pins set by the outside programmer
    @(posedge clk) wp <= 3'h5;
    rst(1'b1, 3'h0);
    chk({om, ws}, 17'h25);
    stop_test();
  end
endmodule
